// ==== sfw_pkg.sv ====
/*
 * Constants, carrier structs and state layout for the store-to-load forwarding block.
 * Assumes one core clock and a synchronous active-high reset in the user module.
 */
package sfw_pkg;
    // ==========================================================
    // sizes
    localparam int SB_N       = 4;
    localparam int LS_N       = 4;
    localparam int AW         = 32;
    localparam int DW         = 64;
    localparam int TAG_W      = 4;
    localparam int PC_W       = 4;
    localparam int ALIAS_BITS = 14;
    localparam logic [2:0] SB_FULL = 3'h4;
    localparam logic [(1<<PC_W)-1:0] PRED_RST = 16'h0000;

    typedef logic [1:0] sfw_sbi_t;

    // ==========================================================
    // load slot states
    typedef enum logic [1:0] {
        LS_FREE = 2'h1,
        LS_PEND = 2'h2
    } sfw_ls_state_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic          valid;
        logic [AW-1:0] addr;
        logic [1:0]    size;
    } sfw_st_req_t;

    typedef struct packed {
        logic             valid;
        logic [AW-1:0]    addr;
        logic [1:0]       size;
        logic [TAG_W-1:0] tag;
        logic [PC_W-1:0]  pc;
    } sfw_ld_req_t;

    typedef struct packed {
        logic             valid;
        logic [TAG_W-1:0] tag;
        logic             fwd;
        logic             pred;
        logic [DW-1:0]    data;
    } sfw_ld_resp_t;

    typedef struct packed {
        logic          valid;
        logic [AW-1:0] addr;
        logic [1:0]    size;
        logic [DW-1:0] data;
    } sfw_cw_t;

    // ==========================================================
    // state
    typedef struct packed {
        logic          valid;
        logic          retired;
        logic          dvalid;
        logic [AW-1:0] addr;
        logic [1:0]    size;
        logic [DW-1:0] data;
    } sfw_sb_t;

    typedef struct packed {
        sfw_ls_state_t    st;
        logic [AW-1:0]    addr;
        logic [1:0]       size;
        logic [TAG_W-1:0] tag;
        logic [PC_W-1:0]  pc;
        logic [SB_N-1:0]  older;
    } sfw_ls_t;

    typedef struct packed {
        sfw_sb_t [SB_N-1:0]      sb;
        sfw_ls_t [LS_N-1:0]      ls;
        sfw_sbi_t                head;
        sfw_sbi_t                tail;
        sfw_sbi_t                ret;
        logic [2:0]              cnt;
        logic [(1<<PC_W)-1:0]    pred;
        logic                    st_rdy;
        logic                    ld_rdy;
        sfw_ld_resp_t            resp;
        sfw_cw_t                 cw;
    } sfw_state_t;
endpackage : sfw_pkg

// ==== sfw_store_fwd.sv ====
/*
 * Store buffer with store-to-load forwarding and load hold slots.
 * Assumes stores allocate and retire in program order, and that every load
 * presented is younger than all stores allocated before its acceptance.
 */
`timescale 1ns/1ns
module sfw_store_fwd (
    input  wire logic                          mclk_i,
    input  wire logic                          srst_i,
    input  wire sfw_pkg::sfw_st_req_t          st_req_i,
    output logic                               st_ready_o,
    output sfw_pkg::sfw_sbi_t                  st_idx_o,
    input  wire logic                          st_data_valid_i,
    input  wire sfw_pkg::sfw_sbi_t             st_data_idx_i,
    input  wire logic [sfw_pkg::DW-1:0]        st_data_i,
    input  wire logic                          st_retire_i,
    input  wire sfw_pkg::sfw_ld_req_t          ld_req_i,
    output logic                               ld_ready_o,
    output sfw_pkg::sfw_ld_resp_t              ld_resp_o,
    output sfw_pkg::sfw_cw_t                   cw_o,
    input  wire logic                          cw_ready_i
);
    // ==========================================================
    // helpers
    function automatic logic overlap(input logic [sfw_pkg::AW-1:0] la, input logic [1:0] lsz,
                                     input logic [sfw_pkg::AW-1:0] sa, input logic [1:0] ssz);
        logic [sfw_pkg::ALIAS_BITS:0] llo;
        logic [sfw_pkg::ALIAS_BITS:0] lhi;
        logic [sfw_pkg::ALIAS_BITS:0] slo;
        logic [sfw_pkg::ALIAS_BITS:0] shi;
        llo = {1'b0, la[sfw_pkg::ALIAS_BITS-1:0]};
        slo = {1'b0, sa[sfw_pkg::ALIAS_BITS-1:0]};
        lhi = llo + (15'h1 << lsz);
        shi = slo + (15'h1 << ssz);
        return (llo < shi) && (slo < lhi);
    endfunction : overlap

    function automatic logic [sfw_pkg::DW-1:0] byte_mask(input logic [1:0] sz);
        logic [sfw_pkg::DW-1:0] m;
        m = '0;
        for (int b = 0; b < sfw_pkg::DW / 8; b++) begin
            if (b < (1 << sz)) begin
                m[b*8 +: 8] = 8'hff;
            end
        end
        return m;
    endfunction : byte_mask

    sfw_pkg::sfw_state_t st_reg;
    sfw_pkg::sfw_state_t st_next;

    logic [sfw_pkg::LS_N-1:0] ls_rdy;
    logic [sfw_pkg::LS_N-1:0] ls_fwd;
    logic [sfw_pkg::DW-1:0]   ls_data [sfw_pkg::LS_N];

    // ==========================================================
    // per-slot forwarding decision
    for (genvar s = 0; s < sfw_pkg::LS_N; s++) begin : g_ls
        always_comb begin
            logic               hit;
            sfw_pkg::sfw_sbi_t  hidx;
            sfw_pkg::sfw_sbi_t  idx;
            sfw_pkg::sfw_ls_t   l;
            sfw_pkg::sfw_sb_t   e;
            hit  = 1'b0;
            hidx = '0;
            idx  = '0;
            e    = '0;
            l    = st_reg.ls[s];
            for (int i = 0; i < sfw_pkg::SB_N; i++) begin
                idx = st_reg.head + i[1:0];
                if (l.older[idx] && overlap(l.addr, l.size, st_reg.sb[idx].addr, st_reg.sb[idx].size)) begin
                    hit  = 1'b1;
                    hidx = idx;
                end
            end
            e          = st_reg.sb[hidx];
            ls_fwd[s]  = 1'b0;
            ls_data[s] = '0;
            if (!hit) begin
                ls_rdy[s] = 1'b1;
            end else if (l.addr == e.addr && l.size <= e.size) begin
                ls_rdy[s]  = e.dvalid;
                ls_fwd[s]  = 1'b1;
                ls_data[s] = e.data & byte_mask(l.size);
            end else if (l.addr[sfw_pkg::AW-1:sfw_pkg::ALIAS_BITS] != e.addr[sfw_pkg::AW-1:sfw_pkg::ALIAS_BITS]) begin
                ls_rdy[s] = e.dvalid;
            end else begin
                ls_rdy[s] = 1'b0;
            end
            if (l.st != sfw_pkg::LS_PEND) begin
                ls_rdy[s] = 1'b0;
            end
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        logic found;
        logic taken;
        logic inc;
        logic dec;
        int   sel;
        int   nfree;
        st_next            = st_reg;
        st_next.resp.valid = 1'b0;
        found = 1'b0;
        taken = 1'b0;
        inc   = 1'b0;
        dec   = 1'b0;
        sel   = 0;
        nfree = 0;

        // commit head store to cache
        if (st_reg.cw.valid) begin
            if (cw_ready_i) begin
                st_next.sb[st_reg.head].valid = 1'b0;
                st_next.head     = st_reg.head + 2'h1;
                st_next.cw.valid = 1'b0;
                dec              = 1'b1;
                for (int s = 0; s < sfw_pkg::LS_N; s++) begin
                    st_next.ls[s].older[st_reg.head] = 1'b0;
                end
            end
        end else if (st_reg.sb[st_reg.head].valid && st_reg.sb[st_reg.head].retired
                     && st_reg.sb[st_reg.head].dvalid) begin
            st_next.cw.valid = 1'b1;
            st_next.cw.addr  = st_reg.sb[st_reg.head].addr;
            st_next.cw.size  = st_reg.sb[st_reg.head].size;
            st_next.cw.data  = st_reg.sb[st_reg.head].data;
        end

        // retire in order
        if (st_retire_i) begin
            st_next.sb[st_reg.ret].retired = 1'b1;
            st_next.ret = st_reg.ret + 2'h1;
        end

        // store data arrival
        if (st_data_valid_i) begin
            st_next.sb[st_data_idx_i].data   = st_data_i;
            st_next.sb[st_data_idx_i].dvalid = 1'b1;
        end

        // store allocation
        if (st_req_i.valid && st_reg.st_rdy) begin
            st_next.sb[st_reg.tail].valid   = 1'b1;
            st_next.sb[st_reg.tail].retired = 1'b0;
            st_next.sb[st_reg.tail].dvalid  = 1'b0;
            st_next.sb[st_reg.tail].addr    = st_req_i.addr;
            st_next.sb[st_reg.tail].size    = st_req_i.size;
            st_next.sb[st_reg.tail].data    = '0;
            st_next.tail = st_reg.tail + 2'h1;
            inc          = 1'b1;
        end
        st_next.cnt = st_reg.cnt + {2'h0, inc} - {2'h0, dec};

        // answer one ready load, predicted ones first
        for (int s = 0; s < sfw_pkg::LS_N; s++) begin
            if (!found && ls_rdy[s] && st_reg.pred[st_reg.ls[s].pc]) begin
                found = 1'b1;
                sel   = s;
            end
        end
        for (int s = 0; s < sfw_pkg::LS_N; s++) begin
            if (!found && ls_rdy[s]) begin
                found = 1'b1;
                sel   = s;
            end
        end
        if (found) begin
            st_next.resp.valid = 1'b1;
            st_next.resp.tag   = st_reg.ls[sel].tag;
            st_next.resp.fwd   = ls_fwd[sel];
            st_next.resp.pred  = st_reg.pred[st_reg.ls[sel].pc];
            st_next.resp.data  = ls_data[sel];
            st_next.ls[sel].st = sfw_pkg::LS_FREE;
            st_next.pred[st_reg.ls[sel].pc] = ls_fwd[sel];
        end

        // accept a new load into a free slot
        for (int s = 0; s < sfw_pkg::LS_N; s++) begin
            if (!taken && ld_req_i.valid && st_reg.ld_rdy) begin
                unique case (st_reg.ls[s].st)
                    sfw_pkg::LS_FREE: begin
                        taken             = 1'b1;
                        st_next.ls[s].st   = sfw_pkg::LS_PEND;
                        st_next.ls[s].addr = ld_req_i.addr;
                        st_next.ls[s].size = ld_req_i.size;
                        st_next.ls[s].tag  = ld_req_i.tag;
                        st_next.ls[s].pc   = ld_req_i.pc;
                        for (int i = 0; i < sfw_pkg::SB_N; i++) begin
                            st_next.ls[s].older[i] = st_reg.sb[i].valid & st_next.sb[i].valid;
                        end
                    end
                    sfw_pkg::LS_PEND: begin
                    end
                endcase
            end
        end

        for (int s = 0; s < sfw_pkg::LS_N; s++) begin
            if (st_next.ls[s].st == sfw_pkg::LS_FREE) begin
                nfree = nfree + 1;
            end
        end
        st_next.ld_rdy = (nfree != 0);
        st_next.st_rdy = (st_next.cnt < sfw_pkg::SB_FULL);

        if (srst_i) begin
            st_next      = '0;
            st_next.pred = sfw_pkg::PRED_RST;
            for (int s = 0; s < sfw_pkg::LS_N; s++) begin
                st_next.ls[s].st = sfw_pkg::LS_FREE;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        st_reg <= st_next;
    end

    // ==========================================================
    // outputs
    assign st_ready_o = st_reg.st_rdy;
    assign st_idx_o   = st_reg.tail;
    assign ld_ready_o = st_reg.ld_rdy;
    assign ld_resp_o  = st_reg.resp;
    assign cw_o       = st_reg.cw;
endmodule : sfw_store_fwd

// ==== sfw_checker.sv ====
/*
 * Port assertions for the store-to-load forwarding block.
 * Assumes it is bound onto sfw_store_fwd, one clock, sync reset.
 */
`timescale 1ns/1ns
module sfw_checker (
    input wire logic                  mclk_i,
    input wire logic                  srst_i,
    input wire sfw_pkg::sfw_st_req_t  st_req_i,
    input wire logic                  st_ready_o,
    input wire sfw_pkg::sfw_sbi_t     st_idx_o,
    input wire logic                  st_retire_i,
    input wire sfw_pkg::sfw_ld_req_t  ld_req_i,
    input wire logic                  ld_ready_o,
    input wire sfw_pkg::sfw_ld_resp_t ld_resp_o,
    input wire sfw_pkg::sfw_cw_t      cw_o,
    input wire logic                  cw_ready_i
);
    // ==========================================================
    // retired stores not yet written, loads not yet answered
    logic [3:0] ret_reg;
    logic [3:0] ld_reg;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ret_reg <= 4'h0;
            ld_reg  <= 4'h0;
        end else begin
            ret_reg <= ret_reg + 4'(st_retire_i) - 4'(cw_o.valid && cw_ready_i);
            ld_reg  <= ld_reg + 4'(ld_req_i.valid && ld_ready_o) - 4'(ld_resp_o.valid);
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // ==========================================================
    // assertions
    AST_CW_RETIRED: assert property (cw_o.valid |-> ret_reg != 4'h0)
        else $error("cache write without retired store");
    AST_CW_HOLD: assert property (cw_o.valid && !cw_ready_i |=> cw_o.valid && $stable(cw_o))
        else $error("cache write dropped or changed while waiting");
    AST_CW_GAP: assert property (cw_o.valid && cw_ready_i |=> !cw_o.valid)
        else $error("cache write right after accepted one");
    AST_NOFWD_ZERO: assert property (ld_resp_o.valid && !ld_resp_o.fwd |-> ld_resp_o.data == 64'h0)
        else $error("unforwarded answer carries data");
    AST_RESP_CAUSE: assert property (ld_resp_o.valid |-> ld_reg != 4'h0)
        else $error("answer without outstanding load");
    AST_ST_ALLOC: assert property (st_req_i.valid && st_ready_o |=> st_idx_o == $past(st_idx_o) + 2'h1)
        else $error("store index did not advance");
    AST_ST_HOLD: assert property (!(st_req_i.valid && st_ready_o) |=> $stable(st_idx_o))
        else $error("store index moved without allocation");
    AST_LD_FULL: assert property (ld_reg == 4'h4 && !ld_resp_o.valid |-> !ld_ready_o)
        else $error("load accepted with all slots held");
endmodule : sfw_checker

bind sfw_store_fwd sfw_checker i_chk (
    .mclk_i     (mclk_i),
    .srst_i     (srst_i),
    .st_req_i   (st_req_i),
    .st_ready_o (st_ready_o),
    .st_idx_o   (st_idx_o),
    .st_retire_i(st_retire_i),
    .ld_req_i   (ld_req_i),
    .ld_ready_o (ld_ready_o),
    .ld_resp_o  (ld_resp_o),
    .cw_o       (cw_o),
    .cw_ready_i (cw_ready_i)
);

// ==== sfw_cache_model.sv ====
/*
 * Cache side model: accepts store writes with random stalls.
 * Assumes cw_i is held by the block until accepted.
 */
`timescale 1ns/1ns
module sfw_cache_model (
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    input  wire sfw_pkg::sfw_cw_t cw_i,
    output logic                  cw_ready_o
);
    integer seed_m;
    initial begin
        seed_m = 4436;
    end
    // ==========================================================
    // random stall on each offered write, driven off the sampling edge
    always @(negedge mclk_i) begin
        cw_ready_o <= !srst_i && cw_i.valid && (($random(seed_m) & 1) != 0);
    end
endmodule : sfw_cache_model

// ==== testbench.sv ====
/*
 * Self-checking bench for the forwarding block with a per-tag answer model.
 * Assumes the cache model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
module testbench;
    logic                  mclk_i, srst_i, st_ready_o, st_data_valid_i, st_retire_i, ld_ready_o, cw_ready_i;
    sfw_pkg::sfw_st_req_t  st_req_i;
    sfw_pkg::sfw_sbi_t     st_idx_o, st_data_idx_i, base;
    logic [63:0]           st_data_i, d0, d1;
    sfw_pkg::sfw_ld_req_t  ld_req_i;
    sfw_pkg::sfw_ld_resp_t ld_resp_o;
    sfw_pkg::sfw_cw_t      cw_o;
    sfw_pkg::sfw_cw_t      cw_q [$];
    logic [63:0]           exp_data [16];
    logic                  exp_fwd [16];
    logic                  pred_m [16];
    logic [31:0]           x;
    integer                fail_count, n_compared, seed, n_resp, n_cw, i;

    sfw_store_fwd i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .st_req_i(st_req_i), .st_ready_o(st_ready_o),
        .st_idx_o(st_idx_o), .st_data_valid_i(st_data_valid_i), .st_data_idx_i(st_data_idx_i),
        .st_data_i(st_data_i), .st_retire_i(st_retire_i), .ld_req_i(ld_req_i), .ld_ready_o(ld_ready_o),
        .ld_resp_o(ld_resp_o), .cw_o(cw_o), .cw_ready_i(cw_ready_i));
    sfw_cache_model i_cache (.mclk_i(mclk_i), .srst_i(srst_i), .cw_i(cw_o), .cw_ready_o(cw_ready_i));

    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic store(input logic [31:0] a, input logic [1:0] s);
        @(negedge mclk_i);
        while (st_ready_o !== 1'b1) @(negedge mclk_i);
        st_req_i = '{1'b1, a, s};
        @(negedge mclk_i);
        st_req_i.valid = 1'b0;
    endtask : store
    task automatic load(input logic [31:0] a, input logic [1:0] s, input logic [3:0] t, input logic f);
        exp_fwd[t] = f;
        exp_data[t] = 64'h0;
        @(negedge mclk_i);
        while (ld_ready_o !== 1'b1) @(negedge mclk_i);
        ld_req_i = '{1'b1, a, s, t, t};
        @(negedge mclk_i);
        ld_req_i.valid = 1'b0;
    endtask : load
    task automatic pulse(input logic dat, input sfw_pkg::sfw_sbi_t k, input logic [63:0] d);
        @(negedge mclk_i);
        st_data_valid_i = dat;
        st_retire_i = !dat;
        st_data_idx_i = k;
        st_data_i = d;
        @(negedge mclk_i);
        st_data_valid_i = 1'b0;
        st_retire_i = 1'b0;
    endtask : pulse

    // ==========================================================
    // answer and cache write model
    always @(posedge mclk_i) begin
        if (ld_resp_o.valid === 1'b1) begin
            n_resp++;
            check("fwd", 128'(ld_resp_o.fwd), 128'(exp_fwd[ld_resp_o.tag]));
            check("data", 128'(ld_resp_o.data), 128'(exp_data[ld_resp_o.tag]));
            check("pred", 128'(ld_resp_o.pred), 128'(pred_m[ld_resp_o.tag]));
            pred_m[ld_resp_o.tag] = exp_fwd[ld_resp_o.tag];
            if (ld_resp_o.tag == 4'h1 || ld_resp_o.tag == 4'h5) check("held load order", 128'(n_cw), 128'(2));
        end
        if (cw_o.valid === 1'b1 && cw_ready_i === 1'b1) begin
            n_cw++;
            check("cache write", 128'(cw_o), 128'(cw_q.pop_front()));
        end
    end

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    initial begin
        #2000000;
        fail_count++;
        test_done();
    end
    initial begin
        {fail_count, n_compared, n_resp, n_cw} = '0;
        seed = 4436;
        srst_i = 1'b1;
        {st_req_i, st_data_valid_i, st_data_idx_i, st_data_i, st_retire_i, ld_req_i} = '0;
        for (i = 0; i < 16; i++) pred_m[i] = 1'b0;
        repeat (8) @(negedge mclk_i);
        srst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        repeat (2) begin
            x = (32'($random(seed)) & 32'h00000ff8) | 32'h00001000;
            d0 = {32'($random(seed)), 32'($random(seed))};
            d1 = {32'($random(seed)), 32'($random(seed))};
            {n_resp, n_cw} = '0;
            base = st_idx_o;
            cw_q.push_back('{1'b1, x, 2'h0, d0});
            cw_q.push_back('{1'b1, x, 2'h2, d1});
            check("store ready", 128'(st_ready_o), 128'(1));
            check("load ready", 128'(ld_ready_o), 128'(1));
            store(x, 2'h0);
            store(x, 2'h2);
            check("store index", 128'(st_idx_o), 128'(sfw_pkg::sfw_sbi_t'(base + 2'h2)));
            load(x + 32'h1, 2'h0, 4'h1, 1'b0);
            load(x, 2'h1, 4'h2, 1'b1);
            exp_data[2] = d1 & 64'hffff;
            load(x + 32'h4000, 2'h0, 4'h3, 1'b0);
            load(x + 32'h100, 2'h0, 4'h4, 1'b0);
            load(x, 2'h3, 4'h5, 1'b0);
            repeat (8) @(negedge mclk_i);
            check("answers before data", 128'(n_resp), 128'(1));
            pulse(1'b1, base, d0);
            pulse(1'b1, base + 2'h1, d1);
            repeat (8) @(negedge mclk_i);
            check("answers after data", 128'(n_resp), 128'(3));
            check("write before retire", 128'(cw_o.valid), 128'(0));
            pulse(1'b0, base, 64'h0);
            pulse(1'b0, base, 64'h0);
            for (i = 0; i < 60 && n_resp < 5; i++) @(negedge mclk_i);
            check("answers total", 128'(n_resp), 128'(5));
        end
        test_done();
    end
endmodule : testbench
